// ### bench/tb_top.sv
// self-checking bench of the uart frame and status unit
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_top;
  localparam int P = 16;
  logic core_clk, sys_rst, reg_wr, reg_rd, rxd, txd, cts_n, rts_n, irq, rd_d;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [7:0] exp_q[$];
  logic [7:0] msk_q[$];
  logic [31:0] rnd;
  int fails, n_checks, cyc, irq_cnt;
  ufsc_top ufsc_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .rx_complete_irq_flag(irq));
  ufsc_remote #(.P(P)) remote_inst (.core_clk(core_clk), .txd(txd), .rxd(rxd));
  // ==========================================
  // clock, read monitor, timeout
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (rd_d) begin
      `CHK("read data", exp_q[0] & msk_q[0], reg_rdata & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    rd_d <= reg_rd;
    if (irq === 1'b1) irq_cnt++;
    cyc++;
    if (cyc > 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ==========================================
  // bus tasks and helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  function automatic logic [7:0] rbyte();
    repeat (8) rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd[7:0];
  endfunction
  // bits after the start bit: data, optional ninth, stop bits
  function automatic void mkf(input logic [7:0] d, input logic [7:0] u, input logic o,
      output logic [11:0] b, output int n);
    b = '0;
    for (int i = 0; i < 8; i++) b[i] = o ? d[7 - i] : d[i];
    n = 8;
    if (u[4] | u[3]) begin
      b[8] = u[3] ? (^d ^ u[5]) : u[5];
      n = 9;
    end
    b[n] = u[1];
    n++;
    if (u[2]) begin
      b[n] = u[1];
      n++;
    end
  endfunction
  // ==========================================
  // transmit case
  task automatic tx_case(input logic [7:0] u, input logic o);
    logic [11:0] b, got;
    int n;
    logic [7:0] d;
    d = rbyte();
    cts_n <= u[6];
    wr(ufsc_pkg::ADDR_CSR, 8'h80);
    wr(ufsc_pkg::ADDR_UCR, u);
    wr(ufsc_pkg::ADDR_GCR, {2'h0, o, 5'h00});
    rd(ufsc_pkg::ADDR_GCR, {2'h0, o, 5'h00}, 8'hFF);
    @(posedge core_clk);
    #1 `CHK("txd idle", ~u[0], txd)
    mkf(d, u, o, b, n);
    fork
      remote_inst.recv(u[0], n, got);
      begin
        wr(ufsc_pkg::ADDR_DBUF, d);
        if (u[6]) begin
          repeat (2 * P) @(posedge core_clk);
          #1 `CHK("txd held", ~u[0], txd)
          @(posedge core_clk);
          cts_n <= 1'b0;
        end else begin
          rd(ufsc_pkg::ADDR_CSR, 8'h01, 8'h01);
        end
      end
    join
    `CHK("tx frame", b, got)
    repeat (P) @(posedge core_clk);
    rd(ufsc_pkg::ADDR_CSR, 8'h02, 8'h03);
    wr(ufsc_pkg::ADDR_CSR, 8'h80);
    rd(ufsc_pkg::ADDR_CSR, 8'h00, 8'h02);
    $display("tx case %h done", u);
  endtask
  // ==========================================
  // receive case, f flips frame bits
  task automatic rx_case(input logic [7:0] u, input logic o, input logic [7:0] cs,
      input logic [11:0] f, input logic [7:0] e, input int ni);
    logic [11:0] b;
    int n, c0;
    logic [7:0] d;
    d = rbyte();
    wr(ufsc_pkg::ADDR_CSR, 8'h80);
    remote_inst.idle(u[0]);
    wr(ufsc_pkg::ADDR_UCR, u);
    wr(ufsc_pkg::ADDR_GCR, {2'h0, o, 5'h00});
    wr(ufsc_pkg::ADDR_CSR, cs);
    mkf(d, u, o, b, n);
    c0 = irq_cnt;
    remote_inst.send(u[0], b ^ f, n);
    repeat (2 * P) @(posedge core_clk);
    `CHK("irq count", ni, irq_cnt - c0)
    rd(ufsc_pkg::ADDR_CSR, e, 8'h1D);
    if (e[2]) rd(ufsc_pkg::ADDR_DBUF, d, 8'hFF);
    #1 `CHK("rts_n", u[6] & ~(cs[6] & ~e[2]), rts_n)
    wr(ufsc_pkg::ADDR_CSR, 8'h80);
    rd(ufsc_pkg::ADDR_CSR, 8'h00, 8'h1C);
    $display("rx case %h done", u);
  endtask
  // ==========================================
  // closing
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cts_n = 1'b0;
    rd_d = 1'b0;
    rnd = 32'h340FAA06;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    irq_cnt = 0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(ufsc_pkg::ADDR_UCR, 8'h02, 8'hFF);
    rd(ufsc_pkg::ADDR_CSR, 8'h00, 8'hFF);
    rd(8'h00, 8'h00, 8'hFF);
    rd(ufsc_pkg::ADDR_BAUD, 8'h00, 8'hFF);
    rd(ufsc_pkg::ADDR_GCR, 8'h00, 8'hFF);
    rd(ufsc_pkg::ADDR_DBUF, 8'h00, 8'hFF);
    wr(ufsc_pkg::ADDR_BAUD, 8'h5A);
    rd(ufsc_pkg::ADDR_BAUD, 8'h5A, 8'hFF);
    wr(ufsc_pkg::ADDR_BAUD, 8'h00);
    $display("reset case done");
    tx_case(8'h02, 1'b0);
    tx_case(8'h2E, 1'b1);
    tx_case(8'h0A, 1'b0);
    tx_case(8'h31, 1'b0);
    tx_case(8'h16, 1'b1);
    tx_case(8'h42, 1'b0);
    rx_case(8'h02, 1'b0, 8'hC0, 12'h000, 8'h04, 1);
    rx_case(8'h2E, 1'b1, 8'hC0, 12'h000, 8'h04, 1);
    rx_case(8'h31, 1'b0, 8'hC0, 12'h000, 8'h04, 1);
    rx_case(8'h0A, 1'b0, 8'hC0, 12'h100, 8'h0C, 1);
    rx_case(8'h02, 1'b0, 8'hC0, 12'h100, 8'h10, 0);
    rx_case(8'h06, 1'b0, 8'hC0, 12'h200, 8'h14, 1);
    rx_case(8'h02, 1'b0, 8'h80, 12'h000, 8'h00, 0);
    rx_case(8'h42, 1'b0, 8'hC0, 12'h000, 8'h04, 1);
    // abort a frame in flight
    wr(ufsc_pkg::ADDR_CSR, 8'h80);
    wr(ufsc_pkg::ADDR_UCR, 8'h02);
    wr(ufsc_pkg::ADDR_DBUF, rbyte());
    repeat (3 * P) @(posedge core_clk);
    wr(ufsc_pkg::ADDR_UCR, 8'h82);
    rd(ufsc_pkg::ADDR_CSR, 8'h00, 8'h03);
    rd(ufsc_pkg::ADDR_UCR, 8'h02, 8'hFF);
    #1 `CHK("txd after flush", 1'b1, txd)
    repeat (12 * P) @(posedge core_clk);
    rd(ufsc_pkg::ADDR_CSR, 8'h00, 8'h03);
    repeat (3) @(posedge core_clk);
    $display("flush case done");
    tally_and_finish();
  end
endmodule // tb_top

// ### bench/ufsc_remote.sv
// remote uart model facing the serial pins
`timescale 1ns/100ps
module ufsc_remote #(
  parameter int P = 16
) (
  input wire logic core_clk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // line rests at the opposite of the start level
  task automatic idle(input logic st);
    rxd <= ~st;
  endtask
  // start bit then n frame bits, same format as the unit
  task automatic send(input logic st, input logic [11:0] b, input int n);
    rxd <= st;
    repeat (P) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      rxd <= b[i];
      repeat (P) @(posedge core_clk);
    end
    rxd <= ~st;
  endtask
  // wait for a start bit, then sample n bits at mid period
  task automatic recv(input logic st, input int n, output logic [11:0] b);
    int k;
    b = '0;
    k = 0;
    while (txd !== st && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    repeat (P / 2) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      repeat (P) @(posedge core_clk);
      b[i] = txd;
    end
  endtask
endmodule // ufsc_remote

// ### hw/ufsc_bit_timer.sv
// bit period timer: one-cycle tick enable at the end of each period
`timescale 1ns/100ps
module ufsc_bit_timer #(
  parameter int W = ufsc_pkg::TMR_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic [W-1:0] load_val,
  input wire logic [W-1:0] period,
  output logic tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } ufsc_tmr_t;
  ufsc_tmr_t t_reg, t_next;
  always_comb begin
    t_next = t_reg;
    t_next.tick = 1'b0;
    if (restart) begin
      t_next.cnt = load_val;
    end else if (t_reg.cnt == '0) begin
      t_next.cnt = period - W'(1);
      t_next.tick = 1'b1;
    end else begin
      t_next.cnt = t_reg.cnt - W'(1);
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end
  assign tick = t_reg.tick;
endmodule // ufsc_bit_timer

// ### hw/ufsc_pkg.sv
// constants, offsets and types of the uart frame and status unit
package ufsc_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CSR = 8'h86;
  localparam logic [7:0] ADDR_DBUF = 8'hC1;
  localparam logic [7:0] ADDR_BAUD = 8'hC2;
  localparam logic [7:0] ADDR_UCR = 8'hC4;
  localparam logic [7:0] ADDR_GCR = 8'hC5;
  // serial_control_status fields
  localparam int CSR_MODE = 7;
  localparam int CSR_RX_EN = 6;
  localparam int CSR_SLAVE = 5;
  localparam int CSR_FRAME_ERR = 4;
  localparam int CSR_ERR = 3;
  localparam int CSR_RXB = 2;
  localparam int CSR_TXB = 1;
  localparam int CSR_ACT = 0;
  // uart_frame_control fields
  localparam int UCR_FLUSH = 7;
  localparam int UCR_FLOW = 6;
  localparam int UCR_NINTH_VAL = 5;
  localparam int UCR_NINE_EN = 4;
  localparam int UCR_PAR = 3;
  localparam int UCR_STOP_CNT = 2;
  localparam int UCR_STOP = 1;
  localparam int UCR_START = 0;
  // bit order field of the generic control register
  localparam int GCR_ORDER = 5;
  // reset values
  localparam logic [6:0] UCR_RESET = 7'h02;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  // timing: cycles per baud step, bit period is (divisor+1) steps
  localparam int BAUD_STEP = 16;
  localparam int DATA_BITS = 8;
  localparam int TMR_W = 13;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_NINTH = 3'h2,
    ST_STOP1 = 3'h6,
    ST_STOP2 = 3'h7
  } ufsc_st_t;
endpackage

// ### hw/ufsc_sync.sv
// two flip-flop synchroniser for a pin input
`timescale 1ns/100ps
module ufsc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic pin_sync
);
  typedef struct packed {
    logic meta;
    logic sync;
  } ufsc_sync_t;
  ufsc_sync_t s_reg, s_next;
  always_comb begin
    s_next.meta = pin_in;
    s_next.sync = s_reg.meta;
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_reg <= {RST_VAL, RST_VAL};
    end else begin
      s_reg <= s_next;
    end
  end
  assign pin_sync = s_reg.sync;
endmodule // ufsc_sync

// ### hw/ufsc_top.sv
// uart framing, flags and control registers
// Function
// - a received stop bit at the wrong level sets the framing error flag
// - rx complete and byte flag rise on good first stop; bad second stop errs later
// - parity failure sets parity error flag, bit 3, cleared only by writing zero
// - a received character ready sets byte received, bit 2, cleared by writing zero
// - last written byte fully sent sets byte transmitted, bit 1, software only clears
// - read-only bit 0 shows one while transmitting or receiving
// - writing one to flush, bit 7, aborts everything to idle; reads zero
// - flow bit 6 enables request-to-send and clear-to-send handshaking
// - without parity in nine-bit mode the ninth bit sends bit 5
// - with parity, bit 5 zero means even parity, one means odd
// - bit 4 selects eight or nine bit characters; parity, bit 3, forces nine
// - bit 3 turns on parity generation and checking
// - bit 2 selects one or two stop bits
// - bit 1, reset one, sets stop bit level for transmit and check
// - bit 0 sets start level; idle line is its opposite
// - bit order setting sends least significant first at zero, most at one
// - reception starts only while receiver enable is one
`timescale 1ns/100ps
module ufsc_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  output logic rts_n,
  output logic rx_complete_irq_flag
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [6:0] ucr;
    logic mode;
    logic rx_en;
    logic slave;
    logic frame_err;
    logic err;
    logic rxb;
    logic txb;
    logic order;
    logic [7:0] baud;
    logic [7:0] txhold;
    logic txpend;
    ufsc_pkg::ufsc_st_t txst;
    logic [8:0] txsh;
    logic [3:0] txcnt;
    logic txd;
    ufsc_pkg::ufsc_st_t rxst;
    logic [8:0] rxsh;
    logic [3:0] rxcnt;
    logic [7:0] rxbuf;
    logic rxirq;
    logic rts_n;
    logic [7:0] rdata;
  } ufsc_state_t;
  ufsc_state_t r_reg, r_next;

  function automatic logic [7:0] ufsc_order(input logic [7:0] d, input logic msb);
    ufsc_order = msb ? {<<{d}} : d;
  endfunction

  // ==========================================================
  // pins and timers
  logic rx_s, cts_s, tx_tick, rx_tick, active_w, flush_w;
  logic [ufsc_pkg::TMR_W-1:0] per_w, half_w;
  logic frm_flow, frm_ninth_val, frm_nine, frm_par, frm_two_stop, frm_stop, frm_start;
  logic [7:0] rx_data_w;
  logic rx_ninth_w, par_bad_w, stop_ok_w;

  ufsc_sync #(.RST_VAL(1'b1)) u_rx_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(rxd),
    .pin_sync(rx_s)
  );
  ufsc_sync #(.RST_VAL(1'b1)) u_cts_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in(cts_n),
    .pin_sync(cts_s)
  );

  assign per_w = {1'b0, r_reg.baud, 4'h0} + ufsc_pkg::TMR_W'(ufsc_pkg::BAUD_STEP);
  assign half_w = per_w >> 1;

  ufsc_bit_timer u_tx_tmr (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .restart(r_reg.txst == ufsc_pkg::ST_IDLE),
    .load_val(per_w - ufsc_pkg::TMR_W'(2)),
    .period(per_w),
    .tick(tx_tick)
  );
  // receiver waits half a period after the start edge to sample mid-bit
  ufsc_bit_timer u_rx_tmr (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .restart(r_reg.rxst == ufsc_pkg::ST_IDLE),
    .load_val(half_w - ufsc_pkg::TMR_W'(1)),
    .period(per_w),
    .tick(rx_tick)
  );

  // ==========================================================
  // decoded format
  assign frm_flow = r_reg.ucr[ufsc_pkg::UCR_FLOW];
  assign frm_ninth_val = r_reg.ucr[ufsc_pkg::UCR_NINTH_VAL];
  assign frm_par = r_reg.ucr[ufsc_pkg::UCR_PAR];
  assign frm_nine = r_reg.ucr[ufsc_pkg::UCR_NINE_EN] | frm_par;
  assign frm_two_stop = r_reg.ucr[ufsc_pkg::UCR_STOP_CNT];
  assign frm_stop = r_reg.ucr[ufsc_pkg::UCR_STOP];
  assign frm_start = r_reg.ucr[ufsc_pkg::UCR_START];
  assign rx_data_w = ufsc_order(r_reg.rxsh[7:0], r_reg.order);
  assign rx_ninth_w = r_reg.rxsh[8];
  assign par_bad_w = frm_par & (rx_ninth_w != (^rx_data_w ^ frm_ninth_val));
  assign stop_ok_w = (rx_s == frm_stop);
  assign active_w = (r_reg.txst != ufsc_pkg::ST_IDLE) | (r_reg.rxst != ufsc_pkg::ST_IDLE)
    | r_reg.txpend;
  assign flush_w = reg_wr & (reg_addr == ufsc_pkg::ADDR_UCR) & reg_wdata[ufsc_pkg::UCR_FLUSH];

  // ==========================================================
  // next state
  always_comb begin
    logic set_frm, set_err, set_rxb, set_txb;
    set_frm = 1'b0;
    set_err = 1'b0;
    set_rxb = 1'b0;
    set_txb = 1'b0;
    r_next = r_reg;
    r_next.rxirq = 1'b0;
    r_next.rdata = 8'h00;
    // register reads, data in the following cycle only
    if (reg_rd) begin
      case (reg_addr)
        ufsc_pkg::ADDR_CSR: r_next.rdata = {r_reg.mode, r_reg.rx_en, r_reg.slave, r_reg.frame_err,
          r_reg.err, r_reg.rxb, r_reg.txb, active_w};
        ufsc_pkg::ADDR_DBUF: r_next.rdata = r_reg.rxbuf;
        ufsc_pkg::ADDR_BAUD: r_next.rdata = r_reg.baud;
        ufsc_pkg::ADDR_UCR: r_next.rdata = {1'b0, r_reg.ucr};
        ufsc_pkg::ADDR_GCR: r_next.rdata = {2'h0, r_reg.order, 5'h00};
        default: r_next.rdata = 8'h00;
      endcase
    end
    // register writes; status flags can only be cleared by software
    if (reg_wr) begin
      case (reg_addr)
        ufsc_pkg::ADDR_CSR: begin
          r_next.mode = reg_wdata[ufsc_pkg::CSR_MODE];
          r_next.rx_en = reg_wdata[ufsc_pkg::CSR_RX_EN];
          r_next.slave = reg_wdata[ufsc_pkg::CSR_SLAVE];
          r_next.frame_err = r_reg.frame_err & reg_wdata[ufsc_pkg::CSR_FRAME_ERR];
          r_next.err = r_reg.err & reg_wdata[ufsc_pkg::CSR_ERR];
          r_next.rxb = r_reg.rxb & reg_wdata[ufsc_pkg::CSR_RXB];
          r_next.txb = r_reg.txb & reg_wdata[ufsc_pkg::CSR_TXB];
        end
        ufsc_pkg::ADDR_DBUF: begin
          r_next.txhold = reg_wdata;
          r_next.txpend = 1'b1;
        end
        ufsc_pkg::ADDR_BAUD: r_next.baud = reg_wdata;
        ufsc_pkg::ADDR_UCR: r_next.ucr = reg_wdata[6:0];
        ufsc_pkg::ADDR_GCR: r_next.order = reg_wdata[ufsc_pkg::GCR_ORDER];
        default: r_next.order = r_reg.order;
      endcase
    end
    // transmitter
    unique case (r_reg.txst)
      ufsc_pkg::ST_IDLE: begin
        r_next.txd = ~frm_start;
        if (r_reg.txpend && (!frm_flow || !cts_s)) begin
          r_next.txst = ufsc_pkg::ST_START;
          r_next.txd = frm_start;
          r_next.txsh = {frm_par ? (^r_reg.txhold ^ frm_ninth_val) : frm_ninth_val,
            ufsc_order(r_reg.txhold, r_reg.order)};
          r_next.txcnt = 4'h0;
          r_next.txpend = reg_wr & (reg_addr == ufsc_pkg::ADDR_DBUF);
        end
      end
      ufsc_pkg::ST_START: begin
        if (tx_tick) begin
          r_next.txst = ufsc_pkg::ST_DATA;
          r_next.txd = r_reg.txsh[0];
        end
      end
      ufsc_pkg::ST_DATA: begin
        if (tx_tick) begin
          r_next.txsh = {1'b0, r_reg.txsh[8:1]};
          r_next.txcnt = r_reg.txcnt + 4'h1;
          if (r_reg.txcnt == 4'(ufsc_pkg::DATA_BITS - 1)) begin
            r_next.txst = frm_nine ? ufsc_pkg::ST_NINTH : ufsc_pkg::ST_STOP1;
            r_next.txd = frm_nine ? r_reg.txsh[1] : frm_stop;
          end else begin
            r_next.txd = r_reg.txsh[1];
          end
        end
      end
      ufsc_pkg::ST_NINTH: begin
        if (tx_tick) begin
          r_next.txst = ufsc_pkg::ST_STOP1;
          r_next.txd = frm_stop;
        end
      end
      ufsc_pkg::ST_STOP1: begin
        if (tx_tick) begin
          r_next.txst = frm_two_stop ? ufsc_pkg::ST_STOP2 : ufsc_pkg::ST_IDLE;
          r_next.txd = frm_two_stop ? frm_stop : ~frm_start;
          set_txb = ~frm_two_stop & ~r_reg.txpend;
        end
      end
      ufsc_pkg::ST_STOP2: begin
        if (tx_tick) begin
          r_next.txst = ufsc_pkg::ST_IDLE;
          r_next.txd = ~frm_start;
          set_txb = ~r_reg.txpend;
        end
      end
      default: r_next.txst = ufsc_pkg::ST_IDLE;
    endcase
    // receiver
    unique case (r_reg.rxst)
      ufsc_pkg::ST_IDLE: begin
        if (r_reg.rx_en && rx_s == frm_start) begin
          r_next.rxst = ufsc_pkg::ST_START;
        end
      end
      ufsc_pkg::ST_START: begin
        if (rx_tick) begin
          r_next.rxst = (rx_s == frm_start) ? ufsc_pkg::ST_DATA : ufsc_pkg::ST_IDLE;
          r_next.rxcnt = 4'h0;
        end
      end
      ufsc_pkg::ST_DATA: begin
        if (rx_tick) begin
          r_next.rxsh[7:0] = {rx_s, r_reg.rxsh[7:1]};
          r_next.rxcnt = r_reg.rxcnt + 4'h1;
          if (r_reg.rxcnt == 4'(ufsc_pkg::DATA_BITS - 1)) begin
            r_next.rxst = frm_nine ? ufsc_pkg::ST_NINTH : ufsc_pkg::ST_STOP1;
            r_next.rxsh[8] = 1'b0;
          end
        end
      end
      ufsc_pkg::ST_NINTH: begin
        if (rx_tick) begin
          r_next.rxsh[8] = rx_s;
          r_next.rxst = ufsc_pkg::ST_STOP1;
        end
      end
      ufsc_pkg::ST_STOP1: begin
        if (rx_tick) begin
          if (stop_ok_w) begin
            set_rxb = 1'b1;
            r_next.rxirq = 1'b1;
            set_err = par_bad_w;
            r_next.rxbuf = rx_data_w;
            r_next.rxst = frm_two_stop ? ufsc_pkg::ST_STOP2 : ufsc_pkg::ST_IDLE;
          end else begin
            set_frm = 1'b1;
            r_next.rxst = ufsc_pkg::ST_IDLE;
          end
        end
      end
      ufsc_pkg::ST_STOP2: begin
        if (rx_tick) begin
          set_frm = ~stop_ok_w;
          r_next.rxst = ufsc_pkg::ST_IDLE;
        end
      end
      default: r_next.rxst = ufsc_pkg::ST_IDLE;
    endcase
    // flush aborts both directions and drops buffered data
    if (flush_w) begin
      r_next.txst = ufsc_pkg::ST_IDLE;
      r_next.rxst = ufsc_pkg::ST_IDLE;
      r_next.txpend = 1'b0;
      r_next.txd = ~reg_wdata[ufsc_pkg::UCR_START];
      r_next.rxbuf = 8'h00;
      r_next.rxirq = 1'b0;
      set_rxb = 1'b0;
      set_txb = 1'b0;
      set_err = 1'b0;
      set_frm = 1'b0;
    end
    // hardware set wins over a software clear in the same cycle
    r_next.frame_err = r_next.frame_err | set_frm;
    r_next.err = r_next.err | set_err;
    r_next.rxb = r_next.rxb | set_rxb;
    r_next.txb = r_next.txb | set_txb;
    // with flow on, ask the far end to send only when a received byte can be taken; asserted always with flow off
    r_next.rts_n = r_next.ucr[ufsc_pkg::UCR_FLOW] ? ~(r_next.rx_en & ~r_next.rxb) : 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.ucr <= ufsc_pkg::UCR_RESET;
      r_reg.baud <= ufsc_pkg::BAUD_RESET;
      r_reg.txd <= 1'b1;
      r_reg.txst <= ufsc_pkg::ST_IDLE;
      r_reg.rxst <= ufsc_pkg::ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign reg_rdata = r_reg.rdata;
  assign txd = r_reg.txd;
  assign rts_n = r_reg.rts_n;
  assign rx_complete_irq_flag = r_reg.rxirq;

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  flush_to_idle_a: assert property (flush_w |=> r_reg.txst == ufsc_pkg::ST_IDLE
    && r_reg.rxst == ufsc_pkg::ST_IDLE && !r_reg.txpend)
    else $error("flush did not idle the unit");
  flush_reads_zero_a: assert property (reg_rd && reg_addr == ufsc_pkg::ADDR_UCR
    |=> !reg_rdata[ufsc_pkg::UCR_FLUSH])
    else $error("flush bit read as one");
  busy_bit_a: assert property (reg_rd && reg_addr == ufsc_pkg::ADDR_CSR
    |=> reg_rdata[ufsc_pkg::CSR_ACT] == $past(active_w))
    else $error("busy bit wrong");
  stop_bad_frame_a: assert property (r_reg.rxst == ufsc_pkg::ST_STOP1 && rx_tick
    && !stop_ok_w && !flush_w |=> r_reg.frame_err && r_reg.rxst == ufsc_pkg::ST_IDLE)
    else $error("bad stop bit without framing error");
  rx_done_flags_a: assert property (r_reg.rxst == ufsc_pkg::ST_STOP1 && rx_tick
    && stop_ok_w && !flush_w |=> r_reg.rxb && rx_complete_irq_flag
    ##1 !rx_complete_irq_flag)
    else $error("receive flags not raised on good stop");
  parity_err_a: assert property (r_reg.rxst == ufsc_pkg::ST_STOP1 && rx_tick
    && stop_ok_w && par_bad_w && !flush_w |=> r_reg.err)
    else $error("parity error not flagged");
  tx_done_a: assert property (r_reg.txst == ufsc_pkg::ST_STOP1 && tx_tick && !frm_two_stop
    && !r_reg.txpend && !flush_w |=> r_reg.txb && r_reg.txst == ufsc_pkg::ST_IDLE)
    else $error("transmit done flag missing");
  start_level_a: assert property (r_reg.txst == ufsc_pkg::ST_START
    |-> txd == frm_start)
    else $error("start bit level wrong");
  stop_level_a: assert property (r_reg.txst == ufsc_pkg::ST_STOP1
    |-> txd == frm_stop)
    else $error("stop bit level wrong");
  rx_disabled_a: assert property (!r_reg.rx_en && r_reg.rxst == ufsc_pkg::ST_IDLE
    |=> r_reg.rxst == ufsc_pkg::ST_IDLE)
    else $error("receiver started while disabled");
  flow_hold_a: assert property (frm_flow && cts_s && r_reg.txst == ufsc_pkg::ST_IDLE
    && !flush_w |=> r_reg.txst == ufsc_pkg::ST_IDLE)
    else $error("transmit started against clear-to-send");

  rx_frame_c: cover property (r_reg.rxst == ufsc_pkg::ST_STOP1 && rx_tick && stop_ok_w);
  tx_two_stop_c: cover property (r_reg.txst == ufsc_pkg::ST_STOP2 && tx_tick);
  rx_ninth_c: cover property (r_reg.rxst == ufsc_pkg::ST_NINTH && rx_tick && frm_par);
  flush_busy_c: cover property (flush_w && active_w);
endmodule // ufsc_top
